// ==== core/efc_consts.vh ====
`ifndef EFC_CONSTS_VH
`define EFC_CONSTS_VH

// ---------------------------------------------------------------
// Frame word control register
// ---------------------------------------------------------------
`define EFC_FWC_ADDR 7'h0a
`define EFC_FWC_RST 24'h07_9000
`define EFC_ECG_OFF_HI 23
`define EFC_ECG_OFF_LO 19
`define EFC_PACE_OFF 14
`define EFC_RESPM_OFF 13
`define EFC_RESPPH_OFF 12
`define EFC_LOFF_OFF 11
`define EFC_GPIO_OFF 10
`define EFC_CRC_OFF 9
`define EFC_AUTO_DROP 7
`define EFC_HDR_RPT 6
`define EFC_FMT_SEL 4
`define EFC_SKIP_HI 3
`define EFC_SKIP_LO 2
`define EFC_RATE_HI 1
`define EFC_RATE_LO 0

// ---------------------------------------------------------------
// Rate codes and decimation shifts (source frames at 128 kHz)
// ---------------------------------------------------------------
`define EFC_RATE_2K 2'h0
`define EFC_RATE_16K 2'h1
`define EFC_RATE_128K 2'h2
`define EFC_SH_2K 4'h6
`define EFC_SH_16K 4'h3
`define EFC_SH_128K 4'h0

// ---------------------------------------------------------------
// Frame slot order
// ---------------------------------------------------------------
`define EFC_SLOT_HDR 4'h0
`define EFC_SLOT_ECG 4'h1
`define EFC_SLOT_PACE 4'h6
`define EFC_SLOT_RESPM 4'h7
`define EFC_SLOT_RESPPH 4'h8
`define EFC_SLOT_LOFF 4'h9
`define EFC_SLOT_GPIO 4'ha
`define EFC_SLOT_CRC 4'hb
`define EFC_NSLOT 12
`define EFC_CRC_POLY 32'h04c1_1db7

`endif

// ==== core/efc_frame_ctl.v ====
`timescale 1ns/100ps
`include "efc_consts.vh"

// ---------------------------------------------------------------
// Output word FIFO with registered read stage
// ---------------------------------------------------------------
module efc_word_fifo #(
  parameter W = 33,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire core_clk, // Core clock
  input wire srst, // Sync reset, high
  input wire in_valid, // Write request
  output wire in_ready, // Space available
  input wire [W-1:0] in_data, // Write word
  output reg out_valid, // Read word valid
  output reg [W-1:0] out_data, // Read word
  input wire out_ready // Reader accepts
);
  localparam [AW:0] FULL = DEPTH[AW:0];
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  reg [AW:0] cnt_reg;
  wire push, pop;

  // Full stalls the emitter, so words are never dropped
  assign in_ready = (cnt_reg != FULL);
  assign push = in_valid && in_ready;
  assign pop = (cnt_reg != 0) && (!out_valid || out_ready);

  // Storage array, no reset needed
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, count and read stage
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_data <= mem[rd_ptr_reg];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      case ({push, pop})
        2'b10: cnt_reg <= cnt_reg + 1'b1;
        2'b01: cnt_reg <= cnt_reg - 1'b1;
        default: cnt_reg <= cnt_reg;
      endcase
    end
  end
endmodule // efc_word_fifo

// Contract
// - ECG word bits 23..19 drop words
// - Word of detached electrode is undefined
// - Bits 14,13,11,10,9 drop optional words
// - Breath phase word dropped after reset
// - Auto drop flagless pace/breath magnitude/contact words
// - Repeat header alone while data not ready
// - Bit 4 picks lead or electrode words
// - Skip field decimates by 1, 2, 4
// - Rate field picks 2k, 16k, 128k
module efc_frame_ctl #(
  parameter W = 32,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter [W-1:0] CRC_POLY = `EFC_CRC_POLY,
  parameter [W-1:0] CRC_INIT = {W{1'b1}}
) (
  input wire core_clk, // Core clock, 50 MHz
  input wire srst, // Sync reset, high
  input wire cfg_wr, // Register write strobe
  input wire [6:0] cfg_addr, // Register address
  input wire [23:0] cfg_wdata, // Register write data
  output reg [23:0] cfg_rdata, // Register read data
  input wire src_valid, // Source frame offered
  output reg src_ready, // Source frame taken
  input wire [W-1:0] src_header, // Frame header word
  input wire src_pace_flag, // Header pace flag
  input wire src_resp_flag, // Header breath flag
  input wire src_loff_flag, // Header contact flag
  input wire [5*W-1:0] src_lead_words, // Lead/vector words
  input wire [5*W-1:0] src_elec_words, // Electrode words
  input wire [W-1:0] src_pace, // Pace word
  input wire [W-1:0] src_resp_mag, // Breath magnitude
  input wire [W-1:0] src_resp_phase, // Breath phase
  input wire [W-1:0] src_loff, // Contact status word
  input wire [W-1:0] src_gpio, // GPIO word
  output wire out_valid, // Frame word valid
  output wire [W-1:0] out_data, // Frame word
  output wire out_last, // Last word of frame
  input wire out_ready // Reader accepts word
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EMIT = 1'b1;
  localparam NS = `EFC_NSLOT;

  reg [23:0] frame_word_control_reg;
  reg state_reg;
  reg [3:0] idx_reg;
  reg [NS-1:0] keep_reg, keep_next;
  reg [W-1:0] crc_reg;
  reg [7:0] cnt_reg;
  reg [W-1:0] slot_mem [0:NS-1];
  wire [5*W-1:0] ecg_sel;
  wire [4:0] ecg_keep;
  wire [1:0] rate_f, skip_f;
  reg [3:0] rate_sh;
  wire [3:0] skip_sh;
  wire [8:0] div_full;
  wire [7:0] div_m1;
  wire data_rdy, fmt_eff, auto_drop, accept;
  wire [NS-1:0] rest;
  wire word_last, word_keep;
  wire [W-1:0] word_data;
  wire fifo_in_valid, fifo_in_ready;
  wire [W:0] fifo_out;
  wire adv, done;

  // ---------------------------------------------------------------
  // CRC step over one word, MSB first
  // ---------------------------------------------------------------
  function [W-1:0] crc_step;
    input [W-1:0] crc;
    input [W-1:0] word;
    integer b;
    reg [W-1:0] c;
    begin
      c = crc;
      for (b = W - 1; b >= 0; b = b - 1) begin
        c = {c[W-2:0], 1'b0} ^ (CRC_POLY & {W{c[W-1] ^ word[b]}});
      end
      crc_step = c;
    end
  endfunction

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Written as given; reserved fields are the host's to fill
  always @(posedge core_clk) begin
    if (srst) begin
      frame_word_control_reg <= `EFC_FWC_RST;
      cfg_rdata <= 24'h00_0000;
    end else begin
      if (cfg_wr && cfg_addr == `EFC_FWC_ADDR) begin
        frame_word_control_reg <= cfg_wdata;
      end
      cfg_rdata <= (cfg_addr == `EFC_FWC_ADDR) ?
                   frame_word_control_reg : 24'h00_0000;
    end
  end

  // ---------------------------------------------------------------
  // Rate and skip decimation
  // ---------------------------------------------------------------
  assign rate_f = frame_word_control_reg[`EFC_RATE_HI:`EFC_RATE_LO];
  assign skip_f = frame_word_control_reg[`EFC_SKIP_HI:`EFC_SKIP_LO];

  // Unused rate code 11 falls back to the slowest rate
  always @* begin
    case (rate_f)
      `EFC_RATE_16K: rate_sh = `EFC_SH_16K;
      `EFC_RATE_128K: rate_sh = `EFC_SH_128K;
      default: rate_sh = `EFC_SH_2K;
    endcase
  end

  assign skip_sh = skip_f[1] ? 4'h2 : {3'h0, skip_f[0]};
  assign div_full = 9'h001 << (rate_sh + skip_sh);
  assign div_m1 = div_full[7:0] - 8'h01;
  assign data_rdy = (cnt_reg == 8'h00);

  // ---------------------------------------------------------------
  // Word selection for the frame being accepted
  // ---------------------------------------------------------------
  // 128k cannot carry lead words, so electrode words are forced
  assign fmt_eff = frame_word_control_reg[`EFC_FMT_SEL] |
                   (rate_f == `EFC_RATE_128K);
  assign auto_drop = frame_word_control_reg[`EFC_AUTO_DROP];

  // Per ECG slot: format mux and drop bit, first slot is bit 23
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_ecg
      assign ecg_sel[g*W +: W] = fmt_eff ? src_elec_words[g*W +: W] :
                                 src_lead_words[g*W +: W];
      assign ecg_keep[g] = ~frame_word_control_reg[`EFC_ECG_OFF_HI - g];
    end
  endgenerate

  // Keep mask; data not ready gives header only or nothing
  always @* begin
    keep_next = {NS{1'b0}};
    if (data_rdy) begin
      keep_next[`EFC_SLOT_HDR] = 1'b1;
      keep_next[5:1] = ecg_keep;
      keep_next[`EFC_SLOT_PACE] =
        ~frame_word_control_reg[`EFC_PACE_OFF] &
        ~(auto_drop & ~src_pace_flag);
      keep_next[`EFC_SLOT_RESPM] =
        ~frame_word_control_reg[`EFC_RESPM_OFF] &
        ~(auto_drop & ~src_resp_flag);
      keep_next[`EFC_SLOT_RESPPH] =
        ~frame_word_control_reg[`EFC_RESPPH_OFF];
      keep_next[`EFC_SLOT_LOFF] =
        ~frame_word_control_reg[`EFC_LOFF_OFF] &
        ~(auto_drop & ~src_loff_flag);
      keep_next[`EFC_SLOT_GPIO] =
        ~frame_word_control_reg[`EFC_GPIO_OFF];
      keep_next[`EFC_SLOT_CRC] =
        ~frame_word_control_reg[`EFC_CRC_OFF];
    end else if (frame_word_control_reg[`EFC_HDR_RPT]) begin
      keep_next[`EFC_SLOT_HDR] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Emission sequencer
  // ---------------------------------------------------------------
  assign accept = src_valid && src_ready;
  assign rest = keep_reg >> idx_reg;
  assign word_last = (rest[NS-1:1] == 0);
  assign word_keep = keep_reg[idx_reg];
  assign word_data = (idx_reg == `EFC_SLOT_CRC) ? crc_reg : slot_mem[idx_reg];
  assign fifo_in_valid = (state_reg == ST_EMIT) && word_keep;
  // Dropped slots before the last kept word cost one cycle each; a full FIFO stalls here
  assign adv = (state_reg == ST_EMIT) && (!word_keep || fifo_in_ready);
  assign done = adv && ((idx_reg == `EFC_SLOT_CRC) ||
                        (word_keep && word_last));

  // Slot capture; whole frame latched so later edits cannot mix
  always @(posedge core_clk) begin
    if (accept) begin
      slot_mem[`EFC_SLOT_HDR] <= src_header;
      slot_mem[1] <= ecg_sel[0*W +: W];
      slot_mem[2] <= ecg_sel[1*W +: W];
      slot_mem[3] <= ecg_sel[2*W +: W];
      slot_mem[4] <= ecg_sel[3*W +: W];
      slot_mem[5] <= ecg_sel[4*W +: W];
      slot_mem[`EFC_SLOT_PACE] <= src_pace;
      slot_mem[`EFC_SLOT_RESPM] <= src_resp_mag;
      slot_mem[`EFC_SLOT_RESPPH] <= src_resp_phase;
      slot_mem[`EFC_SLOT_LOFF] <= src_loff;
      slot_mem[`EFC_SLOT_GPIO] <= src_gpio;
      slot_mem[`EFC_SLOT_CRC] <= {W{1'b0}};
    end
  end

  // Control state of the sequencer
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      src_ready <= 1'b1;
      idx_reg <= 4'h0;
      keep_reg <= {NS{1'b0}};
      crc_reg <= CRC_INIT;
      cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            // Counter wraps early if settings shrank the divisor
            if (cnt_reg >= div_m1) begin
              cnt_reg <= 8'h00;
            end else begin
              cnt_reg <= cnt_reg + 8'h01;
            end
            keep_reg <= keep_next;
            idx_reg <= 4'h0;
            crc_reg <= CRC_INIT;
            if (keep_next != 0) begin
              state_reg <= ST_EMIT;
              src_ready <= 1'b0;
            end
          end
        end
        ST_EMIT: begin
          if (fifo_in_valid && fifo_in_ready &&
              idx_reg != `EFC_SLOT_CRC) begin
            crc_reg <= crc_step(crc_reg, word_data);
          end
          if (done) begin
            state_reg <= ST_IDLE;
            src_ready <= 1'b1;
          end else if (adv) begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          src_ready <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output buffer; its read stage drives the ports from flops
  // ---------------------------------------------------------------
  efc_word_fifo #(
    .W(W + 1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({word_last, word_data}),
    .out_valid(out_valid),
    .out_data(fifo_out),
    .out_ready(out_ready)
  );

  assign out_data = fifo_out[W-1:0];
  assign out_last = fifo_out[W];
endmodule // efc_frame_ctl

// ==== test/efc_frame_monitor.sv ====
`timescale 1ns/100ps
module efc_frame_monitor (
  input wire core_clk, // Core clock
  input wire srst, // Sync reset
  input wire cfg_wr, // Write strobe
  input wire [6:0] cfg_addr, // Address
  input wire [23:0] cfg_wdata, // Write data
  input wire [23:0] cfg_rdata, // Read data
  input wire src_valid, // Frame offered
  input wire src_ready, // Sequencer idle
  input wire out_valid, // Word valid
  input wire [31:0] out_data, // Word
  input wire out_last, // Frame end
  input wire out_ready // Reader accepts
);
  // ---------------------------------------------------------------
  // Shadow of settings and frame counter
  // ---------------------------------------------------------------
  reg [23:0] ctl_sh;
  reg [7:0] cnt;
  reg dchg;
  wire acc = src_valid && src_ready;
  wire [3:0] sh = (ctl_sh[1:0] == 2'b01 ? 4'h3 :
    ctl_sh[1:0] == 2'b10 ? 4'h0 : 4'h6) +
    (ctl_sh[3] ? 4'h2 : {3'b000, ctl_sh[2]});
  wire rdy_f = (cnt & ((8'h01 << sh) - 8'h01)) == 8'h00;
  // Phase unknown once divisor changes mid-count, so stop judging then
  always @(posedge core_clk) begin
    if (srst) begin
      ctl_sh <= 24'h07_9000;
      cnt <= 8'h00;
      dchg <= 1'b0;
    end else begin
      if (cfg_wr && cfg_addr == 7'h0a) begin
        ctl_sh <= cfg_wdata;
        if (cnt != 8'h00) dchg <= 1'b1;
      end
      if (acc) cnt <= cnt + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  rst_values_a:
    assert property (disable iff (1'b0) srst |=> cfg_rdata == 24'h00_0000
      && src_ready && !out_valid) else $error("bad reset state");
  unmapped_read_a:
    assert property (cfg_addr != 7'h0a |=> cfg_rdata == 24'h00_0000)
      else $error("unmapped read not zero");
  rd_after_wr_a:
    assert property (cfg_wr && cfg_addr == 7'h0a ##1 !cfg_wr &&
      cfg_addr == 7'h0a |=> cfg_rdata == $past(cfg_wdata, 2))
      else $error("readback mismatch");
  out_hold_a:
    assert property (out_valid && !out_ready |=> out_valid &&
      $stable(out_data) && $stable(out_last)) else $error("word lost");
  ready_drop_a:
    assert property ($fell(src_ready) |-> $past(src_valid))
      else $error("busy without frame");
  ready_emit_a:
    assert property (acc && rdy_f && !dchg |=> !src_ready)
      else $error("ready frame not sent");
  quiet_skip_a:
    assert property (acc && !rdy_f && !dchg && !ctl_sh[6] |=> src_ready)
      else $error("skipped frame sent");
  hdr_repeat_a:
    assert property (acc && !rdy_f && !dchg && ctl_sh[6] |=> !src_ready)
      else $error("header not repeated");
endmodule // efc_frame_monitor

// ==== test/efc_host_model.sv ====
`timescale 1ns/100ps
module efc_host_model (
  input wire core_clk, // Core clock
  input wire stall, // Hold reader off
  input wire out_valid, // Word offered
  input wire [31:0] out_data, // Word
  input wire out_last, // Frame end
  output logic out_ready // Word taken
);
  logic [31:0] got[$];
  int n_frm = 0;
  int n_full = 0;
  int len = 0;
  int ph = 0;
  initial out_ready = 1'b0;
  // Slow reader: refuses one cycle in three to press on the FIFO
  always @(negedge core_clk) begin
    ph = (ph + 1) % 3;
    out_ready <= !stall && ph != 0;
  end
  // Collect words; a frame longer than one word is a full frame
  always @(posedge core_clk) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      len = len + 1;
      if (out_last) begin
        n_frm = n_frm + 1;
        if (len > 1) n_full = n_full + 1;
        len = 0;
      end
    end
  end
endmodule // efc_host_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
`include "efc_consts.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module tb;
  logic core_clk, srst, cfg_wr, src_valid, src_ready, stall;
  logic [6:0] cfg_addr;
  logic [23:0] cfg_wdata, cfg_rdata;
  logic pf, rf, lf, out_valid, out_last, out_ready;
  logic [31:0] hdr, pace, rm, rp, lo, gp, out_data;
  logic [159:0] lead, elec;
  logic [7:0] fn;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int num_checks = 0;
  efc_frame_ctl uut (.core_clk(core_clk), .srst(srst), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .src_valid(src_valid), .src_ready(src_ready), .src_header(hdr),
    .src_pace_flag(pf), .src_resp_flag(rf), .src_loff_flag(lf),
    .src_lead_words(lead), .src_elec_words(elec), .src_pace(pace),
    .src_resp_mag(rm), .src_resp_phase(rp), .src_loff(lo),
    .src_gpio(gp), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready));
  efc_host_model host (.core_clk(core_clk), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready));
  // ---------------------------------------------------------------
  // Bus and frame tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rst;
    srst = 1;
    repeat (8) @(negedge core_clk);
    srst = 0;
    host.got.delete();
    host.n_frm = 0;
    host.n_full = 0;
    host.len = 0;
  endtask
  task automatic wr(input logic [23:0] d);
    cfg_wr = 1;
    cfg_addr = `EFC_FWC_ADDR;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [23:0] v);
    cfg_addr = a;
    repeat (2) @(negedge core_clk);
    v = cfg_rdata;
  endtask
  // Source holds off until idle; words carry a frame number
  task automatic send(input logic [2:0] f);
    int k;
    // One edge between offers, so valid never toggles twice at once
    @(negedge core_clk);
    for (k = 0; k < 300 && !src_ready; k++) @(negedge core_clk);
    if (k == 300) begin n_fail++; stop_test(); end
    fn++;
    {pf, rf, lf} = f;
    hdr = {24'h0a_5a00, fn};
    for (int i = 0; i < 5; i++) begin
      lead[i*32 +: 32] = {8'h10, i[7:0], 8'h00, fn};
      elec[i*32 +: 32] = {8'h20, i[7:0], 8'h00, fn};
    end
    {pace, rm, rp} = {24'h30_0000, fn, 24'h40_0000, fn, 24'h50_0000, fn};
    {lo, gp} = {24'h60_0000, fn, 24'h70_0000, fn};
    src_valid = 1;
    @(negedge core_clk);
    src_valid = 0;
  endtask
  // Expected CRC: all ones start, MSB first, no final inversion
  function automatic logic [31:0] crc_of();
    logic [31:0] c;
    logic msb;
    c = 32'hffff_ffff;
    foreach (exp_q[i]) begin
      for (int b = 31; b >= 0; b--) begin
        msb = c[31] ^ exp_q[i][b];
        c = {c[30:0], 1'b0} ^ (msb ? `EFC_CRC_POLY : 32'h0000_0000);
      end
    end
    return c;
  endfunction
  task automatic build(input logic [23:0] c);
    logic el;
    el = c[4] || c[1:0] == 2'b10;
    exp_q = {hdr};
    for (int i = 0; i < 5; i++)
      if (!c[23-i]) exp_q.push_back(el ? elec[i*32 +: 32] : lead[i*32 +: 32]);
    if (!c[14] && !(c[7] && !pf)) exp_q.push_back(pace);
    if (!c[13] && !(c[7] && !rf)) exp_q.push_back(rm);
    if (!c[12]) exp_q.push_back(rp);
    if (!c[11] && !(c[7] && !lf)) exp_q.push_back(lo);
    if (!c[10]) exp_q.push_back(gp);
  endtask
  task automatic wait_frm(input int n);
    int k;
    for (k = 0; k < 3000 && host.n_frm < n; k++) @(negedge core_clk);
    if (k == 3000) begin n_fail++; stop_test(); end
  endtask
  task automatic chk(input logic [23:0] c);
    build(c);
    wait_frm(1);
    `CHK("words", exp_q.size() + !c[9], host.got.size())
    foreach (exp_q[i]) `CHK("word", exp_q[i], host.got[i])
    if (!c[9]) `CHK("crc", crc_of(), host.got[exp_q.size()])
    host.got.delete();
    host.n_frm = 0;
  endtask
  task automatic run(input logic [23:0] c, input logic [2:0] f);
    logic [23:0] v;
    rst();
    wr(c);
    rd(`EFC_FWC_ADDR, v);
    `CHK("readback", c, v)
    send(f);
    chk(c);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [23:0] v;
    rst();
    rd(`EFC_FWC_ADDR, v);
    `CHK("ctl_reset", 24'h07_9000, v)
    rd(7'h0b, v);
    `CHK("unmapped", 24'h00_0000, v)
    send(3'b111);
    chk(`EFC_FWC_RST);
  endtask
  task automatic t_words;
    run(24'ha7_c400, 3'b111);
    run(24'h5f_ba12, 3'b111);
    run(24'h07_8201, 3'b111);
  endtask
  task automatic t_auto;
    run(24'h07_8292, 3'b000);
    run(24'h07_8292, 3'b101);
    run(24'h07_8212, 3'b000);
  endtask
  task automatic t_decim;
    logic [23:0] c[8] = '{24'h07_fe40, 24'h07_fe41, 24'h07_fe52,
      24'h07_fe56, 24'h07_fe5a, 24'h07_fe5e, 24'h07_fe05, 24'h07_fe43};
    int nf[8] = '{65, 9, 2, 3, 5, 5, 17, 65};
    for (int j = 0; j < 8; j++) begin
      rst();
      wr(c[j]);
      repeat (nf[j]) send(3'b111);
      wait_frm(c[j][6] ? nf[j] : 2);
      repeat (10) @(negedge core_clk);
      `CHK("full_frames", 2, host.n_full)
      `CHK("frames", c[j][6] ? nf[j] : 2, host.n_frm)
    end
  endtask
  task automatic t_mid;
    rst();
    wr(24'h07_8012);
    send(3'b111);
    wr(24'hff_fe12); // Lands while the frame is still going out
    chk(24'h07_8012);
    send(3'b111);
    chk(24'hff_fe12);
  endtask
  // Reader stalls until the FIFO refuses and the sequencer backs up
  task automatic t_stall;
    rst();
    wr(24'h07_8012);
    stall = 1;
    repeat (3) send(3'b111);
    repeat (60) @(negedge core_clk);
    `CHK("src_ready", 1'b0, src_ready)
    `CHK("out_valid", 1'b1, out_valid)
    stall = 0;
    wait_frm(3);
    `CHK("drained", 36, host.got.size())
  endtask
  // Clock and main sequence
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    {srst, cfg_wr, src_valid, stall, pf, rf, lf} = 7'b100_0000;
    cfg_addr = `EFC_FWC_ADDR;
    {cfg_wdata, fn, hdr, pace, rm, rp, lo, gp, lead, elec} = '0;
    t_reset();
    t_words();
    t_auto();
    t_decim();
    t_mid();
    t_stall();
    stop_test();
  end
endmodule // tb
bind efc_frame_ctl efc_frame_monitor mon (.core_clk(core_clk),
  .srst(srst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .src_valid(src_valid),
  .src_ready(src_ready), .out_valid(out_valid), .out_data(out_data),
  .out_last(out_last), .out_ready(out_ready));
